// ---- src/timcs_regs.svh ----
// register offsets, field positions, reset values and timing counts of the tile mask and context block
// assumes a 32-bit Avalon-MM slave with word addressing in bytes
`ifndef TIMCS_REGS_SVH
`define TIMCS_REGS_SVH

// byte offsets (chosen, one aligned word each)
`define TIMCS_OFF_STALL_CNT 8'h00
`define TIMCS_OFF_STALL_TMO 8'h04
`define TIMCS_OFF_CYC_HI 8'h08
`define TIMCS_OFF_CYC_LO 8'h0c
`define TIMCS_OFF_CRIT 8'h10
`define TIMCS_OFF_CTX_PC 8'h14
`define TIMCS_OFF_CTX_ST 8'h18
`define TIMCS_OFF_ICSTAT 8'h1c
`define TIMCS_OFF_MASK_LO 8'h20
`define TIMCS_OFF_MASK_HI 8'h24
`define TIMCS_OFF_MCLR_LO 8'h28
`define TIMCS_OFF_MCLR_HI 8'h2c
`define TIMCS_OFF_MSET_LO 8'h30
`define TIMCS_OFF_MSET_HI 8'h34

// implemented mask bits; reserved ones stay zero
`define TIMCS_MASK_LO_IMPL 32'hfffc0782
`define TIMCS_MASK_HI_IMPL 32'h0001803f
`define TIMCS_MASK_LO_RST 32'hfffc0782
`define TIMCS_MASK_HI_RST 32'h0001803f

// context state fields
`define TIMCS_CTX_ICS_BIT 2
`define TIMCS_CTX_PL_MSB 1
`define TIMCS_CTX_PL_LSB 0

// stall timer: timeout units of 16 machine cycles
`define TIMCS_STALL_UNIT 5'h10
`define TIMCS_STALL_W 16

// answer value for unmapped reads
`define TIMCS_UNMAPPED 32'h00000000

`endif

// ---- src/timcs_pkg.sv ----
// types shared by the tile mask and context block
// assumes the offsets and field constants come from timcs_regs.svh
package timcs_pkg;

  // interrupt entry capture from the core
  typedef struct packed {
    logic take;
    logic [31:0] pc;
    logic [1:0] priv;
  } timcs_entry_t;

  // stall timer state
  typedef enum logic [1:0] {
    TIMCS_ST_IDLE,
    TIMCS_ST_COUNT,
    TIMCS_ST_FIRED
  } timcs_stall_st_t;

endpackage : timcs_pkg

// ---- src/timcs_top.sv ----
// tile interrupt mask, exceptional context, cycle counter and network stall watchdog
// assumes one 100 MHz clock, synchronous active-high reset, Avalon-MM master on the same clock;
// core-side inputs are on the same clock, the stall level and raw irq lines are on the same clock too
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`include "timcs_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - stall interrupt after timeout times sixteen cycles
// - live stall counter readable and writable
// - 64-bit cycle counter advances every cycle
// - upper and lower halves readable separately
// - critical-section flag used by entry and return
// - entry captures interrupted pc in full
// - context bit 2 records critical section
// - context bits 1:0 hold level, rest zero
// - control status flag at bit 0 only
// - mask bit one disables, zero enables
// - low mask covers interrupts 0 to 31
// - high mask covers 32-37 plus bits 15,16
// - low bits 31..28 data, catch-all, notify
// - low bits 27..22 timers and guards
// - low bits 19,18,10..7,1 xlate, done, restock, memerr
// - mask bits reset one, reserved reset zero
// - high bits 5..2 control, 1 counter, 0 avail
// - high bits 16 and 15, reset one
// - clear alias clears written ones only
// - low clear alias uses low mask positions
// - set alias sets written ones only
// - high clear alias acts on 32-37 plus bits 15,16
module timcs_top #(
  parameter int STALL_W = `TIMCS_STALL_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // core interrupt entry and return
  input wire timcs_pkg::timcs_entry_t irq_entry,
  input wire logic irq_return,
  // raw interrupt sources, low word is 0..31, high word is 32..48
  input wire logic [31:0] irq_raw_low,
  input wire logic [31:0] irq_raw_high,
  input wire logic net_stalled,
  // to the core
  output logic [31:0] irq_deliver_low,
  output logic [31:0] irq_deliver_high,
  output logic user_net_stall_timer,
  output logic irq_critical
);

  initial begin
    if (STALL_W < 1 || STALL_W > 32) $error("timcs_top: STALL_W must be 1..32");
  end

  // rolls the four byte lanes into a merged word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : be_merge

  // expands byte enables to a bit mask for the alias writes
  function automatic logic [31:0] be_bits(input logic [3:0] be);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = {8{be[i]}};
    end
    return r;
  endfunction : be_bits

  //////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second cycle of the request
  logic ack_q;
  logic acc;
  logic wr_en;
  logic [31:0] wmask;
  assign acc = (avs_read || avs_write) && !ack_q;
  assign wr_en = avs_write && ack_q; // lands at the edge where the master sees waitrequest low
  assign wmask = be_bits(avs_byteenable);

  always_ff @(posedge core_clk) begin
    if (rst) ack_q <= 1'b0;
    else ack_q <= acc;
  end

  // waitrequest high at rest so a new request always waits one edge
  always_ff @(posedge core_clk) begin
    if (rst) avs_waitrequest <= 1'b1;
    else avs_waitrequest <= !acc;
  end

  // write strobes, taken in the answer cycle so the write lands with the handshake
  logic we_cnt, we_tmo, we_crit, we_pc, we_st, we_ics;
  logic we_mlo, we_mhi, we_clo, we_chi, we_slo, we_shi;
  assign we_cnt = wr_en && avs_address == `TIMCS_OFF_STALL_CNT;
  assign we_tmo = wr_en && avs_address == `TIMCS_OFF_STALL_TMO;
  assign we_crit = wr_en && avs_address == `TIMCS_OFF_CRIT;
  assign we_pc = wr_en && avs_address == `TIMCS_OFF_CTX_PC;
  assign we_st = wr_en && avs_address == `TIMCS_OFF_CTX_ST;
  assign we_ics = wr_en && avs_address == `TIMCS_OFF_ICSTAT;
  assign we_mlo = wr_en && avs_address == `TIMCS_OFF_MASK_LO;
  assign we_mhi = wr_en && avs_address == `TIMCS_OFF_MASK_HI;
  assign we_clo = wr_en && avs_address == `TIMCS_OFF_MCLR_LO;
  assign we_chi = wr_en && avs_address == `TIMCS_OFF_MCLR_HI;
  assign we_slo = wr_en && avs_address == `TIMCS_OFF_MSET_LO;
  assign we_shi = wr_en && avs_address == `TIMCS_OFF_MSET_HI;

  //////////////////////////////////////////////////////////////////////////////
  // cycle counter
  logic [63:0] cyc_q;
  always_ff @(posedge core_clk) begin
    if (rst) cyc_q <= 64'h0;
    else cyc_q <= cyc_q + 64'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // stall watchdog: prescaler gives one enable every sixteen cycles
  logic [STALL_W-1:0] stall_tmo_q;
  logic [STALL_W-1:0] stall_cnt_q;
  logic [4:0] pre_q;
  logic tick;
  timcs_pkg::timcs_stall_st_t st_q;
  assign tick = pre_q == `TIMCS_STALL_UNIT - 5'h1;

  always_ff @(posedge core_clk) begin
    if (rst) stall_tmo_q <= '0;
    else if (we_tmo) stall_tmo_q <= STALL_W'(be_merge(32'(stall_tmo_q), avs_writedata, avs_byteenable));
  end

  // prescaler restarts with the stall so the first step is a full sixteen cycles
  always_ff @(posedge core_clk) begin
    if (rst || !net_stalled || tick) pre_q <= 5'h0;
    else pre_q <= pre_q + 5'h1;
  end

  // a software restore wins over counting so a saved context resumes exactly
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stall_cnt_q <= '0;
      st_q <= timcs_pkg::TIMCS_ST_IDLE;
    end else if (we_cnt) begin
      stall_cnt_q <= STALL_W'(be_merge(32'(stall_cnt_q), avs_writedata, avs_byteenable));
      st_q <= net_stalled ? timcs_pkg::TIMCS_ST_COUNT : timcs_pkg::TIMCS_ST_IDLE;
    end else begin
      case (st_q)
        timcs_pkg::TIMCS_ST_IDLE: begin
          stall_cnt_q <= stall_tmo_q;
          if (net_stalled) st_q <= timcs_pkg::TIMCS_ST_COUNT;
        end
        timcs_pkg::TIMCS_ST_COUNT: begin
          if (!net_stalled) begin
            stall_cnt_q <= stall_tmo_q;
            st_q <= timcs_pkg::TIMCS_ST_IDLE;
          end else if (tick) begin
            if (stall_cnt_q <= STALL_W'(1)) begin
              stall_cnt_q <= '0;
              st_q <= timcs_pkg::TIMCS_ST_FIRED;
            end else begin
              stall_cnt_q <= stall_cnt_q - STALL_W'(1);
            end
          end
        end
        timcs_pkg::TIMCS_ST_FIRED: begin
          if (!net_stalled) begin
            stall_cnt_q <= stall_tmo_q;
            st_q <= timcs_pkg::TIMCS_ST_IDLE;
          end
        end
        default: st_q <= timcs_pkg::TIMCS_ST_IDLE;
      endcase
    end
  end

  // stall interrupt level, held while the stall persists past the timeout
  always_ff @(posedge core_clk) begin
    if (rst) user_net_stall_timer <= 1'b0;
    else user_net_stall_timer <= st_q == timcs_pkg::TIMCS_ST_FIRED && net_stalled;
  end

  //////////////////////////////////////////////////////////////////////////////
  // critical section flag: entry sets it, return restores the saved bit
  logic crit_q;
  logic [31:0] ctx_pc_q;
  logic [2:0] ctx_st_q;
  always_ff @(posedge core_clk) begin
    if (rst) crit_q <= 1'b0;
    else if (irq_entry.take) crit_q <= 1'b1;
    else if (irq_return) crit_q <= ctx_st_q[`TIMCS_CTX_ICS_BIT];
    else if (we_crit && avs_byteenable[0]) crit_q <= avs_writedata[0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) irq_critical <= 1'b0;
    else if (irq_entry.take) irq_critical <= 1'b1;
    else if (irq_return) irq_critical <= ctx_st_q[`TIMCS_CTX_ICS_BIT];
    else if (we_crit && avs_byteenable[0]) irq_critical <= avs_writedata[0];
  end

  // exceptional context capture; hardware entry beats a software write
  always_ff @(posedge core_clk) begin
    if (rst) ctx_pc_q <= 32'h0;
    else if (irq_entry.take) ctx_pc_q <= irq_entry.pc;
    else if (we_pc) ctx_pc_q <= be_merge(ctx_pc_q, avs_writedata, avs_byteenable);
  end

  always_ff @(posedge core_clk) begin
    if (rst) ctx_st_q <= 3'h0;
    else if (irq_entry.take) ctx_st_q <= {crit_q, irq_entry.priv};
    else if (we_st && avs_byteenable[0]) ctx_st_q <= avs_writedata[2:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt control status bit 0, plain software flag
  logic ics_q;
  always_ff @(posedge core_clk) begin
    if (rst) ics_q <= 1'b0;
    else if (we_ics && avs_byteenable[0]) ics_q <= avs_writedata[0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // mask pair; direct write, then clear alias, then set alias, so the direct write wins
  logic [31:0] mask_lo_q;
  logic [31:0] mask_hi_q;
  logic [31:0] wd_bits;
  assign wd_bits = avs_writedata & wmask;

  always_ff @(posedge core_clk) begin
    if (rst) mask_lo_q <= `TIMCS_MASK_LO_RST;
    else if (we_mlo) mask_lo_q <= be_merge(mask_lo_q, avs_writedata, avs_byteenable) & `TIMCS_MASK_LO_IMPL;
    else if (we_clo) mask_lo_q <= mask_lo_q & ~wd_bits;
    else if (we_slo) mask_lo_q <= (mask_lo_q | wd_bits) & `TIMCS_MASK_LO_IMPL;
  end

  always_ff @(posedge core_clk) begin
    if (rst) mask_hi_q <= `TIMCS_MASK_HI_RST;
    else if (we_mhi) mask_hi_q <= be_merge(mask_hi_q, avs_writedata, avs_byteenable) & `TIMCS_MASK_HI_IMPL;
    else if (we_chi) mask_hi_q <= mask_hi_q & ~wd_bits;
    else if (we_shi) mask_hi_q <= (mask_hi_q | wd_bits) & `TIMCS_MASK_HI_IMPL;
  end

  // bit positions follow the interrupt numbering; the control status flag feeds level0_ctrl_irq (bit 5)
  logic [31:0] raw_hi_eff;
  assign raw_hi_eff = irq_raw_high | {26'h0, ics_q, 5'h0};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_deliver_low <= 32'h0;
      irq_deliver_high <= 32'h0;
    end else begin
      irq_deliver_low <= irq_raw_low & ~mask_lo_q & `TIMCS_MASK_LO_IMPL;
      irq_deliver_high <= raw_hi_eff & ~mask_hi_q & `TIMCS_MASK_HI_IMPL;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux; aliases read zero, unmapped reads zero
  logic [31:0] rd_d;
  always_comb begin
    case (avs_address)
      `TIMCS_OFF_STALL_CNT: rd_d = 32'(stall_cnt_q);
      `TIMCS_OFF_STALL_TMO: rd_d = 32'(stall_tmo_q);
      `TIMCS_OFF_CYC_HI: rd_d = cyc_q[63:32];
      `TIMCS_OFF_CYC_LO: rd_d = cyc_q[31:0];
      `TIMCS_OFF_CRIT: rd_d = {31'h0, crit_q};
      `TIMCS_OFF_CTX_PC: rd_d = ctx_pc_q;
      `TIMCS_OFF_CTX_ST: rd_d = {29'h0, ctx_st_q};
      `TIMCS_OFF_ICSTAT: rd_d = {31'h0, ics_q};
      `TIMCS_OFF_MASK_LO: rd_d = mask_lo_q;
      `TIMCS_OFF_MASK_HI: rd_d = mask_hi_q;
      default: rd_d = `TIMCS_UNMAPPED;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) avs_readdata <= 32'h0;
    else if (acc && avs_read) avs_readdata <= rd_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic [31:0] past_hi_q;
  always_ff @(posedge core_clk) begin
    past_hi_q <= cyc_q[31:0];
  end

  cyc_step_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> cyc_q == $past(cyc_q) + 64'h1)
    else $error("cycle counter did not advance");

  mask_reset_a: assert property (@(posedge core_clk)
    $past(rst) |-> mask_lo_q == `TIMCS_MASK_LO_RST && mask_hi_q == `TIMCS_MASK_HI_RST)
    else $error("mask reset value wrong");

  clear_alias_a: assert property (@(posedge core_clk) disable iff (rst)
    we_clo && !we_mlo |=> (mask_lo_q & $past(wd_bits)) == 32'h0)
    else $error("clear alias left a bit set");

  clear_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    we_chi |=> (mask_hi_q & ~$past(wd_bits)) == ($past(mask_hi_q) & ~$past(wd_bits)))
    else $error("high clear alias disturbed other bits");

  set_alias_a: assert property (@(posedge core_clk) disable iff (rst)
    we_slo |=> (mask_lo_q & ($past(wd_bits) & `TIMCS_MASK_LO_IMPL)) == ($past(wd_bits) & `TIMCS_MASK_LO_IMPL))
    else $error("set alias missed a bit");

  deliver_mask_a: assert property (@(posedge core_clk) disable iff (rst)
    ##1 (irq_deliver_low & $past(mask_lo_q)) == 32'h0)
    else $error("masked interrupt delivered");

  ctx_capture_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_entry.take |=> ctx_pc_q == $past(irq_entry.pc) && ctx_st_q[1:0] == $past(irq_entry.priv))
    else $error("context not captured");

  ctx_ics_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_entry.take |=> ctx_st_q[2] == $past(crit_q) && crit_q)
    else $error("critical bit not saved");

  stall_fire_a: assert property (@(posedge core_clk) disable iff (rst)
    st_q == timcs_pkg::TIMCS_ST_COUNT && net_stalled && tick && stall_cnt_q == STALL_W'(1) && !we_cnt
      |=> st_q == timcs_pkg::TIMCS_ST_FIRED ##1 (user_net_stall_timer || !net_stalled))
    else $error("stall interrupt not raised");

  stall_reload_a: assert property (@(posedge core_clk) disable iff (rst)
    !net_stalled && !we_cnt |=> stall_cnt_q == $past(stall_tmo_q))
    else $error("stall counter not reloaded");

endmodule : timcs_top

// ---- tb/timcs_top_bench.sv ----
// self-checking bench for the tile mask, context, cycle counter and stall watchdog block
// assumes timcs_top with its register map header; the bench acts as the avalon-mm master and the core
`timescale 1ns/100ps
`include "timcs_regs.svh"

module timcs_top_bench;

  ////////////////////////////////////////////////////////////////////////////////
  // stimulus signals given a value at time zero, observed signals left to the device
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  timcs_pkg::timcs_entry_t irq_entry = '0;
  logic irq_return = 1'b0;
  logic [31:0] irq_raw_low = 32'h00000000;
  logic [31:0] irq_raw_high = 32'h00000000;
  logic net_stalled = 1'b0;
  logic [31:0] irq_deliver_low;
  logic [31:0] irq_deliver_high;
  logic user_net_stall_timer;
  logic irq_critical;
  int miscompares = 0;
  int checks = 0;

  // 100 MHz machine clock
  always #5 core_clk = ~core_clk;

  // device under test
  timcs_top uut (
    .core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_entry(irq_entry), .irq_return(irq_return),
    .irq_raw_low(irq_raw_low), .irq_raw_high(irq_raw_high), .net_stalled(net_stalled),
    .irq_deliver_low(irq_deliver_low), .irq_deliver_high(irq_deliver_high),
    .user_net_stall_timer(user_net_stall_timer), .irq_critical(irq_critical)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // verdict; also reached when a bounded wait runs out
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // case equality so an unknown never counts as a match
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic idle(input int k);
    repeat (k) @(posedge core_clk);
  endtask : idle

  // one avalon-mm access; request held until waitrequest is sampled low
  task automatic bus_xfer(input logic wr_en, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= addr;
    avs_writedata <= wdata;
    avs_read <= ~wr_en;
    avs_write <= wr_en;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      tally_and_finish();
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus_xfer

  task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
    logic [31:0] dummy;
    bus_xfer(1'b1, addr, wdata, dummy);
  endtask : wr

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    bus_xfer(1'b0, addr, 32'h00000000, got);
    check(got, exp);
  endtask : rd_chk

  // one-cycle interrupt entry pulse from the core
  task automatic enter(input logic [31:0] pc, input logic [1:0] priv);
    @(posedge core_clk);
    irq_entry <= '{1'b1, pc, priv};
    @(posedge core_clk);
    irq_entry <= '0;
    idle(2);
  endtask : enter

  task automatic leave;
    @(posedge core_clk);
    irq_return <= 1'b1;
    @(posedge core_clk);
    irq_return <= 1'b0;
    idle(2);
  endtask : leave

  // counts cycles until the stall interrupt rises, bounded, and checks the count window
  task automatic wait_fire(input int lo, input int hi);
    int n;
    n = 0;
    while (user_net_stall_timer !== 1'b1 && n < hi + 5) begin
      @(posedge core_clk);
      n++;
    end
    check({31'h0, (n >= lo && n <= hi)}, 32'h1);
  endtask : wait_fire

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] a;
    logic [31:0] b;
    idle(3);
    rst <= 1'b0;
    // reset values and reserved bits
    rd_chk(`TIMCS_OFF_MASK_LO, 32'hfffc0782);
    rd_chk(`TIMCS_OFF_MASK_HI, 32'h0001803f);
    rd_chk(`TIMCS_OFF_CTX_PC, 32'h00000000);
    rd_chk(`TIMCS_OFF_CTX_ST, 32'h00000000);
    rd_chk(`TIMCS_OFF_ICSTAT, 32'h00000000);
    wr(`TIMCS_OFF_MASK_LO, 32'hffffffff);
    rd_chk(`TIMCS_OFF_MASK_LO, `TIMCS_MASK_LO_IMPL);
    wr(`TIMCS_OFF_MCLR_LO, 32'h00000000);
    rd_chk(`TIMCS_OFF_MASK_LO, `TIMCS_MASK_LO_IMPL);
    wr(`TIMCS_OFF_MCLR_LO, 32'hffffffff);
    wr(`TIMCS_OFF_MCLR_HI, 32'hffffffff);
    rd_chk(`TIMCS_OFF_MASK_LO, 32'h00000000);
    rd_chk(`TIMCS_OFF_MASK_HI, 32'h00000000);
    // every bit position: enabled delivers, set alias masks, clear alias enables again
    for (int i = 0; i < 32; i++) begin
      irq_raw_low <= 32'h1 << i;
      irq_raw_high <= 32'h1 << i;
      idle(3);
      check(irq_deliver_low, (32'h1 << i) & `TIMCS_MASK_LO_IMPL);
      check(irq_deliver_high, (32'h1 << i) & `TIMCS_MASK_HI_IMPL);
      wr(`TIMCS_OFF_MSET_LO, 32'h1 << i);
      wr(`TIMCS_OFF_MSET_HI, 32'h1 << i);
      rd_chk(`TIMCS_OFF_MASK_LO, (32'h1 << i) & `TIMCS_MASK_LO_IMPL);
      rd_chk(`TIMCS_OFF_MASK_HI, (32'h1 << i) & `TIMCS_MASK_HI_IMPL);
      check(irq_deliver_low, 32'h00000000);
      check(irq_deliver_high, 32'h00000000);
      wr(`TIMCS_OFF_MCLR_LO, 32'h1 << i);
      wr(`TIMCS_OFF_MCLR_HI, 32'h1 << i);
    end
    irq_raw_low <= 32'h00000000;
    irq_raw_high <= 32'h00000000;
    // alias and unmapped places read zero
    rd_chk(`TIMCS_OFF_MCLR_LO, 32'h00000000);
    rd_chk(8'h40, 32'h00000000);
    // cycle counter: back-to-back reads are three cycles apart, writes ignored
    bus_xfer(1'b0, `TIMCS_OFF_CYC_LO, 32'h0, a);
    bus_xfer(1'b0, `TIMCS_OFF_CYC_LO, 32'h0, b);
    check(b - a, 32'h00000003);
    wr(`TIMCS_OFF_CYC_LO, 32'h00000000);
    bus_xfer(1'b0, `TIMCS_OFF_CYC_LO, 32'h0, a);
    check(a - b, 32'h00000006);
    rd_chk(`TIMCS_OFF_CYC_HI, 32'h00000000);
    // interrupt entry captures pc, level and critical state
    enter(32'h12345678, 2'h2);
    check({31'h0, irq_critical}, 32'h1);
    rd_chk(`TIMCS_OFF_CTX_PC, 32'h12345678);
    rd_chk(`TIMCS_OFF_CTX_ST, 32'h00000002);
    rd_chk(`TIMCS_OFF_CRIT, 32'h00000001);
    enter(32'hfedcba98, 2'h3);
    rd_chk(`TIMCS_OFF_CTX_ST, 32'h00000007);
    leave();
    check({31'h0, irq_critical}, 32'h1);
    wr(`TIMCS_OFF_CTX_ST, 32'h00000000);
    leave();
    check({31'h0, irq_critical}, 32'h0);
    wr(`TIMCS_OFF_CTX_ST, 32'hffffffff);
    rd_chk(`TIMCS_OFF_CTX_ST, 32'h00000007);
    // control status flag reaches bit 5 of the high deliver word when unmasked
    wr(`TIMCS_OFF_ICSTAT, 32'hffffffff);
    rd_chk(`TIMCS_OFF_ICSTAT, 32'h00000001);
    idle(2);
    check(irq_deliver_high, 32'h00000020);
    wr(`TIMCS_OFF_ICSTAT, 32'h00000000);
    idle(2);
    check(irq_deliver_high, 32'h00000000);
    // stall watchdog: timeout of three units, then reload on release
    wr(`TIMCS_OFF_STALL_TMO, 32'h00000003);
    rd_chk(`TIMCS_OFF_STALL_TMO, 32'h00000003);
    net_stalled <= 1'b1;
    wait_fire(47, 66);
    net_stalled <= 1'b0;
    idle(3);
    check({31'h0, user_net_stall_timer}, 32'h0);
    rd_chk(`TIMCS_OFF_STALL_CNT, 32'h00000003);
    // restoring a saved count shortens a long timeout
    wr(`TIMCS_OFF_STALL_TMO, 32'h00000064);
    net_stalled <= 1'b1;
    idle(5);
    wr(`TIMCS_OFF_STALL_CNT, 32'h00000001);
    wait_fire(1, 40);
    net_stalled <= 1'b0;
    idle(3);
    rd_chk(`TIMCS_OFF_STALL_CNT, 32'h00000064);
    tally_and_finish();
  end

endmodule : timcs_top_bench
